/* pkg/iwr_pkg.sv */
// iwr_pkg: constants and carrier types for the bus wait/reservation block
// assumes a 20 MHz ref_clk_in; all widths fixed
package iwr_pkg;
    localparam int CLK_MHZ = 20;
    localparam int FALL_NS = 300;                       // line fall time, ns
    localparam int FALL_CYC = (FALL_NS * CLK_MHZ + 999) / 1000;
    localparam int EXTRA_CLKS = 4;
    localparam int CTL0_STT_BIT = 1;
    localparam int STS_MASTER_STATUS_FLAG_BIT = 7;
    localparam int STS_TRC_BIT = 3;
    localparam logic [7:0] WIDTH_RST = 8'h10;
    localparam logic [3:0] BITS_DATA = 4'h8;
    localparam logic [3:0] BITS_ACK = 4'h9;

    typedef enum logic [2:0] {
        IWR_IDLE = 3'b000,
        IWR_RESV = 3'b001,
        IWR_LOW  = 3'b010,
        IWR_HIGH = 3'b011,
        IWR_WAIT = 3'b100,
        IWR_STOP = 3'b101
    } iwr_state_e;

    typedef struct packed {
        logic [7:0] ctl0;       // bus_control_register_0
        logic [7:0] low_width;  // scl_low_width_register
        logic [7:0] high_width; // scl_high_width_register
        logic [7:0] tx_byte;    // pending byte for bus_shift_register
        logic write_shift;      // one-cycle write to bus_shift_register
        logic ack_generation_enable;
        logic wait_timing_select; // 1: wait after ninth clock, except slave receiver acking (eighth)
        logic wait_release;     // one-cycle release of a wait
    } iwr_ctrl_s;

    typedef struct packed {
        logic [7:0] status;     // bus_status_register
        logic [7:0] shift;      // bus_shift_register
        logic transfer_direction_status;
        logic bus_interface_interrupt;
        logic in_wait;
    } iwr_stat_s;
endpackage

/* hw/iwr_sync.sv */
// iwr_sync: three-flop input synchroniser with agreement filter
// assumes input from outside the ref_clk_in domain
`timescale 1ns/1ps
`default_nettype none
module iwr_sync (
    input wire logic ref_clk_in,  // clock
    input wire logic srst_in,     // sync reset
    input wire logic d_in,        // raw pin
    output logic q_out            // filtered level
);
    logic s1_q, s2_q, s3_q, f_q;
    logic f_d;
    always_comb
    begin
        f_d = (s2_q == s3_q) ? s2_q : f_q;
    end
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            f_q <= 1'b1;
        end
        else
        begin
            s1_q <= d_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= f_d;
        end
    end
    assign q_out = f_q;
endmodule
`default_nettype wire

/* hw/iwr_core.sv */
// iwr_core: serial clock timing, wait stretching, reservation and master status
// assumes open-drain lines resolved outside; software drives the ctrl struct
`timescale 1ns/1ps
`default_nettype none
module iwr_core (
    input wire logic ref_clk_in,              // 20 MHz clock
    input wire logic srst_in,                 // sync reset, active high
    input wire iwr_pkg::iwr_ctrl_s ctrl_in,   // software control
    input wire logic scl_in,                  // serial_clock_line level
    input wire logic sda_in,                  // serial_data_line level
    input wire logic stop_det_in,             // stop condition seen, pulse
    input wire logic addr_match_in,           // slave address match, pulse
    input wire logic slave_tx_in,             // matched read request
    input wire logic arb_lost_in,             // arbitration lost, pulse
    output logic scl_out,                     // clock drive value (0)
    output logic scl_oe_n_out,                // low while pulling clock low
    output var iwr_pkg::iwr_stat_s stat_out   // status to software
);
    import iwr_pkg::*;

    logic scl_s;
    logic sda_s;
    iwr_state_e st_q, st_d;
    logic [9:0] cnt_q, cnt_d;
    logic [3:0] bit_q, bit_d;
    logic master_status_flag_q, master_status_flag_d;
    logic trc_q, trc_d;
    logic irq_q, irq_d;
    logic resv_q, resv_d;
    logic [7:0] shift_q, shift_d;
    logic drive_low;
    logic wait_pt;
    logic start_condition_request;
    logic [3:0] bit_nxt;

    iwr_sync u_scl (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .d_in(scl_in),
        .q_out(scl_s)
    );
    iwr_sync u_sda (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .d_in(sda_in),
        .q_out(sda_s)
    );

    assign start_condition_request = ctrl_in.ctl0[CTL0_STT_BIT];
    // count of high phases once the current one ends
    assign bit_nxt = bit_q + 4'h1;
    // wait point: slave receiver acking stretches after the eighth clock
    always_comb
    begin
        if (!master_status_flag_q && !trc_q && ctrl_in.ack_generation_enable)
            wait_pt = (bit_nxt == BITS_DATA);
        else
            wait_pt = ctrl_in.wait_timing_select ? (bit_nxt == BITS_ACK) : (bit_nxt == BITS_DATA);
    end

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        master_status_flag_d = master_status_flag_q;
        trc_d = trc_q;
        irq_d = 1'b0;
        resv_d = resv_q;
        shift_d = shift_q;
        drive_low = 1'b0;
        if (ctrl_in.write_shift)
            shift_d = ctrl_in.tx_byte;
        if (arb_lost_in)
        begin
            master_status_flag_d = 1'b0;
            irq_d = 1'b1;
        end
        if (addr_match_in)
        begin
            trc_d = slave_tx_in;
            irq_d = 1'b1;
            bit_d = 4'h0;
            st_d = IWR_WAIT;
        end
        unique case (st_q)
            IWR_IDLE:
            begin
                if (start_condition_request && !master_status_flag_q)
                begin
                    if (scl_s && sda_s)
                    begin
                        master_status_flag_d = 1'b1;
                        trc_d = 1'b1;
                        bit_d = 4'h0;
                        cnt_d = {2'b00, ctrl_in.low_width};
                        st_d = IWR_LOW;
                    end
                    else
                    begin
                        resv_d = 1'b1;  // bus busy: reserve
                        st_d = IWR_RESV;
                    end
                end
            end
            IWR_RESV:
            begin
                if (stop_det_in)
                begin
                    shift_d = ctrl_in.tx_byte;
                    cnt_d = 10'({2'b00, ctrl_in.low_width} + {2'b00, ctrl_in.high_width}
                        + 10'(EXTRA_CLKS) + 10'(2 * FALL_CYC));
                    st_d = IWR_STOP;
                end
            end
            IWR_STOP:
            begin
                if (cnt_q != 10'h000)
                    cnt_d = cnt_q - 10'h001;
                else
                begin
                    resv_d = 1'b0;
                    master_status_flag_d = 1'b1;
                    trc_d = 1'b1;
                    bit_d = 4'h0;
                    cnt_d = {2'b00, ctrl_in.low_width};
                    st_d = IWR_LOW;
                end
            end
            IWR_LOW:
            begin
                drive_low = 1'b1;
                if (cnt_q != 10'h000)
                    cnt_d = cnt_q - 10'h001;
                else
                begin
                    cnt_d = {2'b00, ctrl_in.high_width};
                    st_d = IWR_HIGH;
                end
            end
            IWR_HIGH:
            begin
                // high period counts only once the line is sensed high
                if (scl_s)
                begin
                    if (cnt_q != 10'h000)
                        cnt_d = cnt_q - 10'h001;
                    else
                    begin
                        bit_d = (bit_nxt == BITS_ACK) ? 4'h0 : bit_nxt;
                        cnt_d = {2'b00, ctrl_in.low_width};
                        st_d = IWR_LOW;
                    end
                end
            end
            IWR_WAIT:
            begin
                drive_low = 1'b1;
                if (ctrl_in.wait_release)
                begin
                    // bit count kept: a wait after the eighth clock resumes with the ninth
                    cnt_d = {2'b00, ctrl_in.high_width};
                    st_d = master_status_flag_q ? IWR_HIGH : IWR_IDLE;
                end
            end
            default:
            begin
                st_d = IWR_IDLE;
            end
        endcase
        if ((st_q == IWR_HIGH) && (st_d == IWR_LOW) && wait_pt)
        begin
            irq_d = 1'b1;
            st_d = IWR_WAIT;
        end
        if (stop_det_in && st_q != IWR_RESV)
        begin
            master_status_flag_d = 1'b0;
            irq_d = 1'b1;
            st_d = IWR_IDLE;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            st_q <= IWR_IDLE;
            cnt_q <= 10'h000;
            bit_q <= 4'h0;
            master_status_flag_q <= 1'b0;
            trc_q <= 1'b0;
            irq_q <= 1'b0;
            resv_q <= 1'b0;
            shift_q <= 8'h00;
            scl_oe_n_out <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            master_status_flag_q <= master_status_flag_d;
            trc_q <= trc_d;
            irq_q <= irq_d;
            resv_q <= resv_d;
            shift_q <= shift_d;
            scl_oe_n_out <= !drive_low;
        end
    end

    assign scl_out = 1'b0;
    always_comb
    begin
        stat_out.status = 8'h00;
        stat_out.status[STS_MASTER_STATUS_FLAG_BIT] = master_status_flag_q;
        stat_out.status[STS_TRC_BIT] = trc_q;
        stat_out.shift = shift_q;
        stat_out.transfer_direction_status = trc_q;
        stat_out.bus_interface_interrupt = irq_q;
        stat_out.in_wait = (st_q == IWR_WAIT);
    end

    wait_holds_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (st_q == IWR_WAIT && !ctrl_in.wait_release) |=> !scl_oe_n_out)
        else $error("clock not held low during wait");
    resv_time_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (st_q == IWR_RESV && stop_det_in) |=> (st_q == IWR_STOP
        && cnt_q == 10'({2'b00, $past(ctrl_in.low_width)} + {2'b00, $past(ctrl_in.high_width)}
        + 10'(EXTRA_CLKS) + 10'(2 * FALL_CYC))))
        else $error("reservation wait length wrong");
    resv_load_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (st_q == IWR_RESV && stop_det_in) |=> shift_q == $past(ctrl_in.tx_byte))
        else $error("reserved byte not loaded on stop");
    master_status_flag_bit_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        stat_out.status[STS_MASTER_STATUS_FLAG_BIT] == master_status_flag_q)
        else $error("master flag misplaced");
    high_sense_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (st_q == IWR_HIGH && !scl_s && !stop_det_in && !addr_match_in) |=> $stable(cnt_q))
        else $error("high period counted with line low");
    match_irq_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        addr_match_in |=> (stat_out.bus_interface_interrupt
        && trc_q == $past(slave_tx_in)))
        else $error("match did not request first byte");
    low_count_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (st_q == IWR_LOW && cnt_q != 10'h000 && !stop_det_in && !addr_match_in)
        |=> cnt_q == $past(cnt_q) - 10'h001)
        else $error("low period count wrong");
    stt_start_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (st_q == IWR_IDLE && start_condition_request && !master_status_flag_q && !stop_det_in && !addr_match_in)
        |=> (st_q == IWR_LOW || st_q == IWR_RESV))
        else $error("start request ignored");
endmodule
`default_nettype wire

/* sim/iwr_bus_peer.sv */
// iwr_bus_peer: far-side bus party that can hold and stretch the clock
// assumes open-drain lines with pull-ups, one reference clock
`timescale 1ns/1ps
`default_nettype none
module iwr_bus_peer (
    input wire logic ref_clk_in,       // clock
    input wire logic dut_oe_n_in,      // block pulls clock low when 0
    input wire logic hold_in,          // peer holds clock low (busy)
    input wire logic [7:0] stretch_in, // wait cycles after each release
    output logic scl_out,              // resolved clock line
    output logic sda_out               // resolved data line
);
    logic [7:0] cnt_q = 8'h00;
    logic prev_q = 1'b1;
    logic rel;
    assign rel = dut_oe_n_in & !prev_q;
    always_ff @(posedge ref_clk_in)
    begin
        prev_q <= dut_oe_n_in;
        if (rel)
            cnt_q <= stretch_in; // not ready: keep clock low
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    // wired-and: high only once every party lets go
    assign scl_out = dut_oe_n_in & !hold_in & (cnt_q == 8'h00) & !(rel & (stretch_in != 8'h00));
    assign sda_out = 1'b1; // released, pull-up
endmodule
`default_nettype wire

/* sim/iwr_core_tb_top.sv */
// iwr_core_tb_top: directed bench for iwr_core with a stretching peer
// assumes 20 MHz clock; inputs driven on falling edges
`timescale 1ns/1ps
`default_nettype none
module iwr_core_tb_top;
    import iwr_pkg::*;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    iwr_ctrl_s ctrl = '0;
    logic stop_det = 1'b0;
    logic addr_match = 1'b0;
    logic slave_tx = 1'b0;
    logic arb_lost = 1'b0;
    logic hold = 1'b0;
    logic [7:0] stretch = 8'h00;
    logic scl_line, sda_line, scl_drv, oe_n;
    logic oe_p = 1'b1;
    iwr_stat_s stat;
    int failures = 0;
    int num_checks = 0;
    int rises = 0;
    int c, n, e;

    initial
    begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    iwr_core u_iwr_core (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .ctrl_in(ctrl),
        .scl_in(scl_line), .sda_in(sda_line), .stop_det_in(stop_det),
        .addr_match_in(addr_match), .slave_tx_in(slave_tx), .arb_lost_in(arb_lost),
        .scl_out(scl_drv), .scl_oe_n_out(oe_n), .stat_out(stat));
    iwr_bus_peer u_iwr_bus_peer (.ref_clk_in(ref_clk_in), .dut_oe_n_in(oe_n),
        .hold_in(hold), .stretch_in(stretch), .scl_out(scl_line), .sda_out(sda_line));

    // counts clock releases by the block
    always @(posedge ref_clk_in)
    begin
        if (oe_n === 1'b1 && oe_p === 1'b0)
            rises++;
        oe_p <= oe_n;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t got=0x%h exp=0x%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk_in);
    endtask

    task automatic wait_oe(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (oe_n !== v && cnt < lim)
        begin
            tick(1);
            cnt++;
        end
    endtask

    task automatic pulse_end;
        arb_lost = 1'b1;
        tick(1);
        check({stat.bus_interface_interrupt, stat.status[STS_MASTER_STATUS_FLAG_BIT]}, 2'b10);
        arb_lost = 1'b0;
        stop_det = 1'b1;
        tick(1);
        stop_det = 1'b0;
        tick(8);
        check(stat.status[STS_MASTER_STATUS_FLAG_BIT], 1'b0);
        check(oe_n, 1'b1);
    endtask

    task automatic xfer(input logic wts, input logic [7:0] st, input int exp_hi);
        int k;
        stretch = st;
        ctrl.wait_timing_select = wts;
        rises = 0;
        ctrl.ctl0[CTL0_STT_BIT] = 1'b1;
        wait_oe(1'b0, 40, k);
        check(stat.status[STS_MASTER_STATUS_FLAG_BIT], 1'b1);
        ctrl.ctl0[CTL0_STT_BIT] = 1'b0;
        wait_oe(1'b1, 600, k);
        check(k, 32'(ctrl.low_width) + 1);
        k = 0;
        while (stat.in_wait !== 1'b1 && k < 3000)
        begin
            tick(1);
            k++;
        end
        tick(2);
        check(rises, exp_hi);
        check(oe_n, 1'b0);
        check(scl_drv, 1'b0);
        hold = 1'b1;
        ctrl.wait_release = 1'b1;
        tick(1);
        ctrl.wait_release = 1'b0;
        tick(20);
        check(oe_n, 1'b1);
        check(rises, exp_hi + 1);
        hold = 1'b0;
        wait_oe(1'b0, 60, k);
        check(k > 32'(ctrl.high_width), 1'b1);
        pulse_end();
        $display("transfer test done, wait select %0d", wts);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #(50 * 40000);
        failures++;
        give_verdict();
    end

    initial
    begin
        ctrl.low_width = 8'h05;
        ctrl.high_width = 8'h04;
        ctrl.ack_generation_enable = 1'b1;
        tick(10);
        srst_in = 1'b0;
        tick(2);
        check({stat.status, stat.shift, stat.bus_interface_interrupt, oe_n}, 18'h1);
        ctrl.tx_byte = 8'h3c;
        ctrl.write_shift = 1'b1;
        tick(1);
        ctrl.write_shift = 1'b0;
        tick(2);
        check(stat.shift, 8'h3c);
        $display("reset test done");
        xfer(1'b0, 8'h00, 8);
        xfer(1'b1, 8'h03, 9);
        hold = 1'b1;
        tick(8);
        ctrl.tx_byte = 8'ha5;
        ctrl.ctl0[CTL0_STT_BIT] = 1'b1;
        tick(10);
        ctrl.ctl0[CTL0_STT_BIT] = 1'b0;
        check(stat.status[STS_MASTER_STATUS_FLAG_BIT], 1'b0);
        check(oe_n, 1'b1);
        hold = 1'b0;
        tick(8);
        stop_det = 1'b1;
        tick(1);
        stop_det = 1'b0;
        wait_oe(1'b0, 400, c);
        e = 32'(ctrl.low_width) + 32'(ctrl.high_width) + EXTRA_CLKS + 2 * FALL_CYC + 1;
        check(c >= e - 1 && c <= e + 2, 1'b1);
        check(stat.shift, 8'ha5);
        pulse_end();
        $display("reservation test done");
        for (int i = 0; i < 2; i++)
        begin
            slave_tx = i[0];
            addr_match = 1'b1;
            tick(1);
            addr_match = 1'b0;
            n = 0;
            repeat (4)
            begin
                if (stat.bus_interface_interrupt === 1'b1)
                    n++;
                tick(1);
            end
            check(n, 1);
            check(stat.transfer_direction_status, i[0]);
            check(stat.status[STS_TRC_BIT], i[0]);
            stop_det = 1'b1;
            tick(1);
            check(stat.bus_interface_interrupt, 1'b1);
            stop_det = 1'b0;
            tick(4);
        end
        $display("slave test done");
        give_verdict();
    end
endmodule
`default_nettype wire
